// *** mgmt_pkg.sv ***
// Shared constants and types of the serial management link.
package mgmt_pkg;

	// ************************************************************
	// Frame layout.
	// ************************************************************
	localparam logic [5:0] idle_ones      = 6'h20;
	localparam logic [7:0] header_bits    = 8'h0e;
	localparam logic [7:0] single_bits    = 8'h10;
	localparam logic [7:0] multi_bits     = 8'hb0;
	localparam logic [4:0] reg_count      = 5'h0b;
	localparam logic [4:0] multi_select   = 5'h1f;
	localparam logic [4:0] phy_address    = 5'h00;
	localparam logic [1:0] dir_read       = 2'h2;
	localparam logic [1:0] dir_write      = 2'h1;
	localparam int         hdr_dir_pos    = 12;
	localparam int         hdr_dev_pos    = 7;
	localparam int         hdr_sel_pos    = 2;
	localparam logic [15:0] data_reset    = 16'h0000;

	// ************************************************************
	// Station registers and clock timing.
	// ************************************************************
	localparam logic [11:0] ctrl_offset   = 12'h000;
	localparam logic [11:0] status_offset = 12'h004;
	localparam int          ctrl_mdc_bit  = 0;
	localparam int          ctrl_out_bit  = 1;
	localparam int          ctrl_drv_bit  = 2;
	localparam int          stat_in_bit   = 0;
	localparam logic [2:0]  ctrl_reset    = 3'h2;
	localparam int pclk_period_ns         = 40;
	localparam int mdc_min_half_ns        = 160;
	localparam int mdc_min_period_ns      = 400;
	localparam int mdc_min_half_cycles =
		(mdc_min_half_ns + pclk_period_ns - 1) / pclk_period_ns;
	localparam int mdc_min_period_cycles =
		(mdc_min_period_ns + pclk_period_ns - 1) / pclk_period_ns;

	typedef enum logic [2:0]
	{
		st_wait_idle,
		st_idle,
		st_start,
		st_header,
		st_data
	} port_state_type;

endpackage

// *** mgmt_if.sv ***
// Two-wire management link between station and port.
interface mgmt_if;
	logic mdc;
	logic host_mdio_o;
	logic host_mdio_oe_n;
	logic dev_mdio_o;
	logic dev_mdio_oe_n;
	logic mdio;

	// The line has a pull-up, so a released line reads as one.
	assign mdio = (host_mdio_oe_n ? 1'b1 : host_mdio_o)
		& (dev_mdio_oe_n ? 1'b1 : dev_mdio_o);

	modport station
	(
		output mdc,
		output host_mdio_o,
		output host_mdio_oe_n,
		input  mdio
	);

	modport phy
	(
		input  mdc,
		input  mdio,
		output dev_mdio_o,
		output dev_mdio_oe_n
	);
endinterface

// *** mgmt_station.sv ***
// Station end: APB registers that software toggles to drive the link.
module mgmt_station
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	mgmt_if.station          link
);

	// ************************************************************
	// State.
	// ************************************************************
	typedef struct packed
	{
		logic [2:0]  ctrl;
		logic [2:0]  dio_s;
		logic        dio_f;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} station_state_type;

	station_state_type q;
	station_state_type d;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == mgmt_pkg::ctrl_offset)
			|| (a == mgmt_pkg::status_offset);
	endfunction

	// ************************************************************
	// Next state.
	// ************************************************************
	always_comb
	begin
		d = q;
		d.dio_s = {q.dio_s[1:0], link.mdio};
		if (q.dio_s[1] == q.dio_s[2])
		begin
			d.dio_f = q.dio_s[2];
		end
		d.pready = 1'b0;
		d.pslverr = 1'b0;
		if (psel && !penable)
		begin
			d.pready = 1'b1;
			d.pslverr = !mapped(paddr);
			d.prdata = 32'h0000_0000;
			if (!pwrite && paddr == mgmt_pkg::ctrl_offset)
			begin
				d.prdata[2:0] = q.ctrl;
			end
			if (!pwrite && paddr == mgmt_pkg::status_offset)
			begin
				d.prdata[mgmt_pkg::stat_in_bit] = q.dio_f;
			end
		end
		// Clock and data edges come only from software writes. R04 R01
		if (psel && penable && q.pready && pwrite
			&& paddr == mgmt_pkg::ctrl_offset)
		begin
			d.ctrl = pwdata[2:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.ctrl <= mgmt_pkg::ctrl_reset;
		end
		else
		begin
			q <= d;
		end
	end

	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign link.mdc = q.ctrl[mgmt_pkg::ctrl_mdc_bit];
	assign link.host_mdio_o = q.ctrl[mgmt_pkg::ctrl_out_bit];
	assign link.host_mdio_oe_n = !q.ctrl[mgmt_pkg::ctrl_drv_bit];

endmodule

// *** mgmt_port.sv ***
// Port end: serial management slave holding eleven data registers.
//
// The implementer's own choices: register access over APB and the register addresses.

// Functional notes
// R01 - Line driven and sampled on clock rise.
// R02 - Station keeps clock phases 160ns, period 400ns.
// R03 - Clock may stretch or pause freely.
// R04 - Host software builds all framing and timing.
// R05 - Idle after 32 ones, stays while ones.
// R06 - Output released while idle.
// R07 - Pattern 01 from idle starts a cycle.
// R08 - Fourteen header bits shifted in, line released.
// R09 - Sixteen data bits in or out.
// R10 - At end: stop, latch data, release line.
// R11 - No new cycle before fresh idle.
// R12 - 32 bits, or 192 in multi mode.
// R13 - Station always writes first sixteen bits; the bench writes fifteen and releases the last.
// R14 - Multi mode moves all eleven registers.
// R15 - Station sends start bits as 01.
// R16 - Two direction bits follow the start.
// R17 - Five device then five select bits.
// R18 - Turnaround bit carries no content.
// R19 - Data uses register chosen by select field.
// R20 - Answer only device address 00000.
// R21 - Drive only during read data bits.
// R22 - Bad start bits: wait for fresh idle.
module mgmt_port
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          multi_en,
	output logic [10:0][15:0]  data_regs,
	output logic               wr_strobe,
	output logic [4:0]         wr_select,
	output logic               frame_active,
	mgmt_if.phy                link
);

	// ************************************************************
	// State.
	// ************************************************************
	typedef struct packed
	{
		logic [2:0]                 mdc_s;
		logic                       mdc_f;
		logic [2:0]                 dio_s;
		logic                       dio_f;
		mgmt_pkg::port_state_type   state;
		logic [5:0]                 ones;
		logic [7:0]                 cnt;
		logic [13:0]                hdr;
		logic                       is_read;
		logic                       matched;
		logic                       multi;
		logic [4:0]                 sel;
		logic [175:0]               shift;
		logic [10:0][15:0]          regs;
		logic                       dout;
		logic                       oe_n;
		logic                       wr_strobe;
		logic [4:0]                 wr_select;
		logic                       busy;
	} port_reg_type;

	port_reg_type q;
	port_reg_type d;
	logic         rise;
	logic         bit_in;
	logic [7:0]   last_cnt;

	function automatic logic [15:0] reg_of
	(
		input logic [10:0][15:0] r,
		input logic [4:0]        s
	);
		reg_of = 16'h0000;
		if (s < mgmt_pkg::reg_count)
		begin
			reg_of = r[s[3:0]];
		end
	endfunction

	// ************************************************************
	// Next state.
	// ************************************************************
	always_comb
	begin
		d = q;
		d.wr_strobe = 1'b0;
		// The clock is only sampled, so a stretched or paused clock
		// simply yields no edge. R03 R01
		d.mdc_s = {q.mdc_s[1:0], link.mdc};
		d.dio_s = {q.dio_s[1:0], link.mdio};
		if (q.mdc_s[1] == q.mdc_s[2])
		begin
			d.mdc_f = q.mdc_s[2];
		end
		if (q.dio_s[1] == q.dio_s[2])
		begin
			d.dio_f = q.dio_s[2];
		end
		rise = d.mdc_f && !q.mdc_f;
		bit_in = d.dio_f;
		last_cnt = q.multi ? mgmt_pkg::multi_bits - 8'h01
			: mgmt_pkg::single_bits - 8'h01;
		if (rise)
		begin
			if (bit_in)
			begin
				if (q.ones != mgmt_pkg::idle_ones)
				begin
					d.ones = q.ones + 6'h01;
				end
			end
			else
			begin
				d.ones = 6'h00;
			end
			unique case (q.state)
				mgmt_pkg::st_wait_idle:
				begin
					// A fresh run of ones is needed after any frame. R11 R05
					if (bit_in && q.ones >= mgmt_pkg::idle_ones - 6'h01)
					begin
						d.state = mgmt_pkg::st_idle;
					end
				end
				mgmt_pkg::st_idle:
				begin
					// Ones keep the port idle; a zero is the first
					// start bit. R05 R07
					if (!bit_in)
					begin
						d.state = mgmt_pkg::st_start;
					end
				end
				mgmt_pkg::st_start:
				begin
					if (bit_in)
					begin
						d.state = mgmt_pkg::st_header; // R07
						d.cnt = 8'h00;
						d.busy = 1'b1;
					end
					else
					begin
						d.state = mgmt_pkg::st_wait_idle; // R22
					end
				end
				mgmt_pkg::st_header:
				begin
					// The line stays released while the header comes
					// in. R08 R13
					d.hdr = {q.hdr[12:0], bit_in};
					d.cnt = q.cnt + 8'h01;
					if (q.cnt == mgmt_pkg::header_bits - 8'h01)
					begin
						// Direction, device address, select; the last two
						// bits are turnaround and are not used. R16 R17 R18
						d.is_read = d.hdr[mgmt_pkg::hdr_dir_pos +: 2]
							== mgmt_pkg::dir_read;
						d.matched = (d.hdr[mgmt_pkg::hdr_dev_pos +: 5]
							== mgmt_pkg::phy_address) // R20
							&& (d.is_read
							|| d.hdr[mgmt_pkg::hdr_dir_pos +: 2]
							== mgmt_pkg::dir_write);
						d.sel = d.hdr[mgmt_pkg::hdr_sel_pos +: 5];
						d.multi = multi_en
							&& d.sel == mgmt_pkg::multi_select; // R12
						d.cnt = 8'h00;
						d.state = mgmt_pkg::st_data;
						if (d.multi)
						begin
							d.shift = q.regs; // R14
						end
						else
						begin
							d.shift = {reg_of(q.regs, d.sel),
								160'h0}; // R19
						end
						if (d.is_read && d.matched)
						begin
							d.dout = d.shift[175]; // R09 R21
							d.oe_n = 1'b0;
						end
					end
				end
				mgmt_pkg::st_data:
				begin
					d.cnt = q.cnt + 8'h01;
					if (q.is_read)
					begin
						d.shift = {q.shift[174:0], 1'b0};
						d.dout = d.shift[175]; // R09
					end
					else
					begin
						d.shift = {q.shift[174:0], bit_in}; // R09
					end
					if (q.cnt == last_cnt)
					begin
						// Stop shifting, latch, release the line. R10 R06
						d.oe_n = 1'b1;
						d.dout = 1'b1;
						d.busy = 1'b0;
						d.ones = 6'h00;
						d.state = mgmt_pkg::st_wait_idle; // R11
						if (!q.is_read && q.matched)
						begin
							d.wr_strobe = 1'b1;
							d.wr_select = q.sel;
							if (q.multi)
							begin
								d.regs = d.shift; // R14
							end
							else if (q.sel < mgmt_pkg::reg_count)
							begin
								d.regs[q.sel[3:0]] = d.shift[15:0]; // R19
							end
						end
					end
				end
			endcase
		end
	end

	// ************************************************************
	// Registers.
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			q <= '0;
			q.state <= mgmt_pkg::st_wait_idle;
			q.mdc_s <= 3'h0;
			q.dio_s <= 3'h7;
			q.dio_f <= 1'b1;
			q.dout <= 1'b1;
			q.oe_n <= 1'b1;
			q.regs <= {11{mgmt_pkg::data_reset}};
		end
		else
		begin
			q <= d;
		end
	end

	assign data_regs = q.regs;
	assign wr_strobe = q.wr_strobe;
	assign wr_select = q.wr_select;
	assign frame_active = q.busy;
	assign link.dev_mdio_o = q.dout;
	assign link.dev_mdio_oe_n = q.oe_n;

endmodule

// *** mgmt_monitor.sv ***
// Checker of the wire between the station and the port.
module mgmt_monitor
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mdc,
	input wire logic host_mdio_o,
	input wire logic host_mdio_oe_n,
	input wire logic dev_mdio_o,
	input wire logic dev_mdio_oe_n,
	input wire logic mdio
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Frame tracking.
	// ****
	// Positions follow the raw clock, so they lead the port's
	// synchronised view by a few cycles; the bounds leave room for it.
	logic        mdc_q;
	logic [5:0]  ones_q;
	logic [7:0]  pos_q;
	logic [7:0]  gap_q;
	logic [13:0] hdr_q;
	logic        ok_q;
	logic        turn_q;
	logic        rise;
	logic [7:0]  ph_q;
	logic [7:0]  per_q;

	assign rise = mdc & ~mdc_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mdc_q  <= 1'b0;
			ones_q <= 6'h00;
			pos_q  <= 8'hff;
			gap_q  <= 8'hff;
			hdr_q  <= 14'h0000;
			ok_q   <= 1'b0;
			turn_q <= 1'b0;
			ph_q   <= 8'hff;
			per_q  <= 8'hff;
		end
		else
		begin
			mdc_q  <= mdc;
			turn_q <= rise & (pos_q == 8'h0f);
			gap_q  <= rise ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
			ph_q   <= (mdc != mdc_q) ? 8'h00
				: ph_q + {7'h00, ph_q != 8'hff};
			per_q  <= rise ? 8'h00 : per_q + {7'h00, per_q != 8'hff};
			if (rise)
			begin
				ones_q <= mdio ? ones_q + {5'h00, ones_q != 6'h3f} : 6'h00;
				pos_q  <= (ones_q[5] & ~mdio) ? 8'h01
					: pos_q + {7'h00, pos_q != 8'hff};
				if (pos_q == 8'h01)
					ok_q <= mdio;
				if (pos_q > 8'h01 && pos_q < 8'h10)
					hdr_q <= {hdr_q[12:0], mdio};
			end
		end
	end

	default clocking dc @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// ****
	// Wire checks.
	// ****
	a_no_contention:
		assert property (!dev_mdio_oe_n |-> host_mdio_oe_n)
		else $error("contention");
	a_idle_release:
		assert property (ones_q[5] |-> dev_mdio_oe_n)
		else $error("drive in idle");
	a_drive_start:
		assert property ($fell(dev_mdio_oe_n) |-> pos_q == 8'h10)
		else $error("drive start");
	a_drive_header:
		assert property ($fell(dev_mdio_oe_n) |-> ok_q
			&& hdr_q[13:7] == 7'h40)
		else $error("drive on bad frame");
	a_read_answer:
		assert property (turn_q && ok_q && hdr_q[13:7] == 7'h40
			&& hdr_q[6:2] < 5'h0b |-> ##[1:10] !dev_mdio_oe_n)
		else $error("read missed");
	a_drive_hold:
		assert property ($fell(dev_mdio_oe_n) |-> !dev_mdio_oe_n [*8])
		else $error("drive short");
	a_bit_stable:
		assert property (!dev_mdio_oe_n && $changed(dev_mdio_o)
			|-> gap_q <= 8'h08)
		else $error("data off edge");
	a_release_end:
		assert property ($rose(dev_mdio_oe_n) |-> pos_q == 8'h20
			|| (hdr_q[6:2] == 5'h1f && pos_q == 8'hc0))
		else $error("release position");
	a_clock_phase:
		assert property (mdc != mdc_q
			|-> ph_q >= mgmt_pkg::mdc_min_half_cycles - 1)
		else $error("clock phase short");
	a_clock_period:
		assert property (rise
			|-> per_q >= mgmt_pkg::mdc_min_period_cycles - 1)
		else $error("clock period short");
endmodule

// *** tb_top.sv ***
// Bench driving the station end of the link through the station registers; the port end answers on its own.
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic [11:0]       paddr = 12'h000;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [31:0]       pwdata = 32'h0000_0000;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              multi_en = 1'b0;
	logic [10:0][15:0] data_regs;
	logic              wr_strobe;
	logic [4:0]        wr_select;
	logic              frame_active;
	logic              busy_seen;
	logic [175:0]      rd;
	logic [175:0]      exp_all;
	logic [31:0]       r;
	logic              e;
	int                num_errors;
	int                total_checks;
	int                wr_cnt;
	int                cycles;
	int                hold = 4;
	mgmt_if link ();
	mgmt_station u_mgmt_station (.pclk, .presetn, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .link);
	mgmt_port u_mgmt_port (.pclk, .presetn, .multi_en, .data_regs,
		.wr_strobe, .wr_select, .frame_active, .link);
	mgmt_monitor u_mgmt_monitor (.pclk, .presetn, .mdc(link.mdc),
		.host_mdio_o(link.host_mdio_o),
		.host_mdio_oe_n(link.host_mdio_oe_n),
		.dev_mdio_o(link.dev_mdio_o),
		.dev_mdio_oe_n(link.dev_mdio_oe_n), .mdio(link.mdio));

	always #20 pclk = ~pclk;

	task automatic check(input logic [175:0] seen, input logic [175:0] want);
		total_checks++;
		if (seen !== want)
		begin
			num_errors++;
			$display("unexpected at %0t: %0h not %0h", $time, seen, want);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// The line is sampled just before the rise, as the station sees it.
	task automatic mbit(input logic drv, input logic d, output logic s);
		apb(1'b1, mgmt_pkg::ctrl_offset, {29'h0, drv, d, 1'b0});
		repeat (hold) @(posedge pclk);
		apb(1'b0, mgmt_pkg::status_offset, 32'h0);
		s = r[0];
		apb(1'b1, mgmt_pkg::ctrl_offset, {29'h0, drv, d, 1'b1});
		repeat (hold) @(posedge pclk);
	endtask

	task automatic frame(input int pre, input logic [3:0] sd,
		input logic [4:0] dev, input logic [4:0] sel, input int n,
		input logic [15:0] wd);
		logic [15:0] hdr;
		logic        s;
		hdr = {sd, dev, sel, 2'b11};
		repeat (pre)
			mbit(1'b1, 1'b1, s);
		for (int i = 15; i >= 0; i--)
			mbit(i > 0, hdr[i], s);
		busy_seen = frame_active;
		for (int i = n - 1; i >= 0; i--)
		begin
			mbit(sd[1:0] == mgmt_pkg::dir_write, wd[i[3:0]], s);
			rd[i] = s;
		end
		repeat (8) @(posedge pclk);
	endtask

	task automatic print_verdict;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	always @(posedge pclk)
	begin
		cycles++;
		if (wr_strobe === 1'b1)
			wr_cnt++;
		if (cycles == 50000)
		begin
			num_errors++;
			print_verdict;
		end
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check(link.dev_mdio_oe_n, 1'b1);
		apb(1'b0, 12'h008, 32'h0);
		check({e, r}, 33'h1_0000_0000);
		apb(1'b0, mgmt_pkg::ctrl_offset, 32'h0);
		check({e, r}, {30'h0, mgmt_pkg::ctrl_reset});
		for (int k = 0; k < 11; k++)
		begin
			exp_all[16 * k +: 16] = {4{k[3:0]}};
			frame(32, 4'h5, 5'h00, k[4:0], 16, {4{k[3:0]}});
			check(busy_seen, 1'b1);
			check(data_regs[k], {4{k[3:0]}});
			check(wr_select, k[4:0]);
		end
		check(frame_active, 1'b0);
		$display("write test done");
		frame(0, 4'h5, 5'h00, 5'h05, 16, 16'h0f0f);
		check(busy_seen, 1'b0);
		check(data_regs[5], 16'h5555);
		frame(32, 4'h1, 5'h00, 5'h06, 16, 16'h0f0f);
		check(busy_seen, 1'b0);
		frame(0, 4'h5, 5'h00, 5'h06, 16, 16'h0f0f);
		check(data_regs[6], 16'h6666);
		frame(32, 4'h5, 5'h01, 5'h07, 16, 16'h0f0f);
		check(data_regs[7], 16'h7777);
		frame(32, 4'h7, 5'h00, 5'h08, 16, 16'h0f0f);
		check(data_regs[8], 16'h8888);
		check(wr_cnt, 11);
		$display("refusal test done");
		hold = 20;
		frame(32, 4'h6, 5'h00, 5'h02, 16, 16'h0000);
		hold = 4;
		check(rd[15:0], 16'h2222);
		frame(32, 4'h6, 5'h00, 5'h1f, 16, 16'h0000);
		check(rd[15:0], 16'h0000);
		multi_en <= 1'b1;
		frame(32, 4'h6, 5'h00, 5'h1f, 176, 16'h0000);
		check(rd, exp_all);
		frame(32, 4'h5, 5'h00, 5'h1f, 176, 16'h1234);
		check(data_regs, {11{16'h1234}});
		check(wr_select, 5'h1f);
		$display("read test done");
		print_verdict;
	end
endmodule
